// File: hdl/pbm_port_b_mux.sv
// Port B alternate-function mux with its register slave.
// Assumes peripherals drive their enables and outputs from the same clock.
// How it works
// R1 - Global pull-up disable kills every pull-up.
// R2 - SPI master forces MISO pin to input.
// R3 - SPI slave forces SCK pin to input.
// R4 - SPI slave forces MOSI pin to input.
// R5 - Forced SPI inputs keep gated output-bit pull-up.
// R6 - SPI supplies the value of its owned output pins; the direction bit still decides drive.
// R7 - Stage 2 outputs map to pins 1,2,7,0.
// R8 - Retriggerable stage output 1 drives pin 3.
// R9 - Pin 0 value: stage, comparator, else the port output bit.
// R10 - Pin 7 captures, pin 0 counts timer 1.
// R11 - Pins 2 and 5 feed external interrupts.
// R12 - Software keeps comparator inputs pulled-up off.
// R13 - Analog input disable turns digital input off, except on enabled interrupt pins.
// R14 - Peripheral output enable forces driver on.
// R15 - Plain pull-up needs input, bit one, enabled.
// R16 - Direction override replaces the direction bit.
// R17 - Value override replaces the output bit.
// R18 - Enabled interrupt pins bypass the sleep clamp.
module pbm_port_b_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pbm_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pad_i,
  output logic [7:0] pad_o,
  output logic [7:0] pad_oe_n_o,
  output logic [7:0] pullup_o,
  input wire logic sleep_i,
  input wire logic spi_block_enable_i,
  input wire logic spi_master_select_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_mosi_out_i,
  input wire logic spi_miso_out_i,
  output logic spi_sck_in_o,
  output logic spi_mosi_in_o,
  output logic spi_miso_in_o,
  input wire logic [3:0] stage2_out_i,
  input wire logic [3:0] stage2_out_enable_i,
  input wire logic retrig_stage_out1_i,
  input wire logic retrig_stage_out1_enable_i,
  input wire logic comparator3_output_i,
  input wire logic comparator3_out_enable_i,
  input wire logic [7:0] analog_input_disable_i,
  input wire logic ext_irq0_enabled_i,
  input wire logic ext_irq1_enabled_i,
  output logic timer1_capture_input_o,
  output logic timer1_count_input_o,
  output logic ext_irq0_input_o,
  output logic ext_irq1_input_o,
  output logic [7:0] mcu_control_o
);
  import pbm_pkg::*;
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] dir_w, out_w, din_w, drv_en_w, drv_val_w, mcu_w;
  pbm_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .pin_state_i(din_w),
    .mcu_control_o(mcu_w),
    .port_dir_o(dir_w),
    .port_out_o(out_w)
  );
  assign mcu_control_o = mcu_w;
  wire logic global_pullup_disable = mcu_w[BIT_PULLUP_DIS]; // [R1]
  // ****************************************************************
  // Override sources
  // ****************************************************************
  wire logic spi_m = spi_block_enable_i & spi_master_select_i;
  wire logic spi_s = spi_block_enable_i & ~spi_master_select_i;
  logic [7:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov;
  wire logic pin0_en = stage2_out_enable_i[3] | comparator3_out_enable_i;
  // Priority for pin 0 value.
  wire logic pin0_val = stage2_out_enable_i[3] ? stage2_out_i[3] :
                        comparator3_out_enable_i ? comparator3_output_i : 1'b0; // [R9]
  always_comb begin
    pu_oe = 8'h00;
    pu_ov = 8'h00;
    dd_oe = 8'h00;
    dd_ov = 8'h00;
    pv_oe = 8'h00;
    pv_ov = 8'h00;
    die_oe = analog_input_disable_i; // [R13]
    die_ov = 8'h00;
    // Forced SPI inputs keep their pull-up from the output bit.
    pu_oe[PIN_MISO] = spi_m; // [R5]
    pu_ov[PIN_MISO] = out_w[PIN_MISO] & ~global_pullup_disable; // [R5]
    dd_oe[PIN_MISO] = spi_m; // [R2]
    pv_oe[PIN_MISO] = spi_s; // [R6]
    pv_ov[PIN_MISO] = spi_miso_out_i; // [R6]
    pu_oe[PIN_SCK] = spi_s; // [R5]
    pu_ov[PIN_SCK] = out_w[PIN_SCK] & ~global_pullup_disable; // [R5]
    dd_oe[PIN_SCK] = spi_s; // [R3]
    pv_oe[PIN_SCK] = spi_m; // [R6]
    pv_ov[PIN_SCK] = spi_sck_out_i; // [R6]
    pu_oe[PIN_MOSI] = spi_s; // [R5]
    pu_ov[PIN_MOSI] = out_w[PIN_MOSI] & ~global_pullup_disable; // [R5]
    dd_oe[PIN_MOSI] = spi_s; // [R4]
    pv_oe[PIN_MOSI] = spi_m; // [R6]
    pv_ov[PIN_MOSI] = spi_mosi_out_i; // [R6]
    // Stage outputs force drive on.
    dd_oe[PIN_ST2_0] = stage2_out_enable_i[0]; // [R7] [R14]
    dd_ov[PIN_ST2_0] = 1'b1;
    pv_oe[PIN_ST2_0] = stage2_out_enable_i[0];
    pv_ov[PIN_ST2_0] = stage2_out_i[0];
    dd_oe[PIN_ST2_1] = stage2_out_enable_i[1]; // [R7] [R14]
    dd_ov[PIN_ST2_1] = 1'b1;
    pv_oe[PIN_ST2_1] = stage2_out_enable_i[1];
    pv_ov[PIN_ST2_1] = stage2_out_i[1];
    dd_oe[PIN_ST2_2] = stage2_out_enable_i[2]; // [R7] [R14]
    dd_ov[PIN_ST2_2] = 1'b1;
    pv_oe[PIN_ST2_2] = stage2_out_enable_i[2];
    pv_ov[PIN_ST2_2] = stage2_out_i[2];
    dd_oe[PIN_ST2_3] = pin0_en; // [R7] [R14]
    dd_ov[PIN_ST2_3] = 1'b1;
    pv_oe[PIN_ST2_3] = pin0_en;
    pv_ov[PIN_ST2_3] = pin0_val; // [R9]
    dd_oe[PIN_RETRIG1] = retrig_stage_out1_enable_i; // [R8] [R14]
    dd_ov[PIN_RETRIG1] = 1'b1;
    pv_oe[PIN_RETRIG1] = retrig_stage_out1_enable_i;
    pv_ov[PIN_RETRIG1] = retrig_stage_out1_i; // [R8]
    // Enabled interrupt pins stay awake; otherwise analog disable rules.
    die_oe[PIN_IRQ0] = ext_irq0_enabled_i | analog_input_disable_i[PIN_IRQ0]; // [R18]
    die_ov[PIN_IRQ0] = ext_irq0_enabled_i; // [R11]
    die_oe[PIN_IRQ1] = ext_irq1_enabled_i | analog_input_disable_i[PIN_IRQ1]; // [R18]
    die_ov[PIN_IRQ1] = ext_irq1_enabled_i; // [R11]
  end
  // ****************************************************************
  // Pin cells
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++) begin : g_pin
      pbm_pin_cell u_cell (
        .dir_bit_i(dir_w[gi]),
        .out_bit_i(out_w[gi]),
        .pullup_dis_i(global_pullup_disable),
        .sleep_i(sleep_i),
        .pullup_ovr_en_i(pu_oe[gi]),
        .pullup_ovr_val_i(pu_ov[gi]),
        .dir_ovr_en_i(dd_oe[gi]),
        .dir_ovr_val_i(dd_ov[gi]),
        .value_ovr_en_i(pv_oe[gi]),
        .value_ovr_val_i(pv_ov[gi]),
        .input_enable_ovr_en_i(die_oe[gi]),
        .input_enable_ovr_val_i(die_ov[gi]),
        .pad_i(pad_i[gi]),
        .drive_en_o(drv_en_w[gi]),
        .drive_val_o(drv_val_w[gi]),
        .pullup_o(pullup_o[gi]),
        .din_o(din_w[gi])
      );
    end
  endgenerate
  assign pad_o = drv_val_w;
  assign pad_oe_n_o = ~drv_en_w;
  // ****************************************************************
  // Peripheral inputs
  // ****************************************************************
  assign timer1_capture_input_o = din_w[PIN_CAPTURE]; // [R10]
  assign timer1_count_input_o = din_w[PIN_COUNT]; // [R10]
  assign ext_irq0_input_o = din_w[PIN_IRQ0]; // [R11]
  assign ext_irq1_input_o = din_w[PIN_IRQ1]; // [R11]
  assign spi_sck_in_o = din_w[PIN_SCK];
  assign spi_mosi_in_o = din_w[PIN_MOSI];
  assign spi_miso_in_o = din_w[PIN_MISO];
  // ****************************************************************
  // Checks
  // ****************************************************************
  pud_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    global_pullup_disable |-> pullup_o == 8'h00) else $error("pull-up on while disabled");
  miso_in_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    spi_m |-> pad_oe_n_o[PIN_MISO]) else $error("miso driven as master");
  sck_in_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    spi_s |-> pad_oe_n_o[PIN_SCK]) else $error("sck driven as slave");
  mosi_in_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    spi_s |-> pad_oe_n_o[PIN_MOSI]) else $error("mosi driven as slave");
  spi_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    spi_m |-> pullup_o[PIN_MISO] == (out_w[PIN_MISO] & ~global_pullup_disable)) else $error("miso pull-up");
  spi_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (spi_m && dir_w[PIN_SCK]) |-> pad_o[PIN_SCK] == spi_sck_out_i) else $error("sck value");
  stage_pin7_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    stage2_out_enable_i[2] |-> !pad_oe_n_o[PIN_ST2_2] && pad_o[PIN_ST2_2] == stage2_out_i[2])
    else $error("stage pin 7");
  retrig_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    retrig_stage_out1_enable_i |-> pad_o[PIN_RETRIG1] == retrig_stage_out1_i)
    else $error("retrig pin 3");
  pin0_prio_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (!stage2_out_enable_i[3] && comparator3_out_enable_i) |->
    pad_o[PIN_ST2_3] == comparator3_output_i) else $error("pin 0 priority");
  irq_awake_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (ext_irq0_enabled_i && sleep_i) |-> ext_irq0_input_o == pad_i[PIN_IRQ0])
    else $error("irq0 clamped");
  plain_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    (!spi_block_enable_i && dir_w[1]) |-> !pullup_o[1]) else $error("pull-up on output");
  // ****************************************************************
  // Pin checks
  // ****************************************************************
  sck_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    spi_s |-> pullup_o[PIN_SCK] == (out_w[PIN_SCK] & ~global_pullup_disable))
    else $error("sck pull-up");
  mosi_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    spi_s |-> pullup_o[PIN_MOSI] == (out_w[PIN_MOSI] & ~global_pullup_disable))
    else $error("mosi pull-up");
  mosi_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (spi_m && dir_w[PIN_MOSI]) |-> pad_o[PIN_MOSI] == spi_mosi_out_i)
    else $error("mosi value");
  miso_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (spi_s && dir_w[PIN_MISO]) |-> pad_o[PIN_MISO] == spi_miso_out_i)
    else $error("miso value");
  miso_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    spi_s |-> pad_oe_n_o[PIN_MISO] == !dir_w[PIN_MISO])
    else $error("miso direction as slave");
  sck_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    spi_m |-> pad_oe_n_o[PIN_SCK] == !dir_w[PIN_SCK])
    else $error("sck direction as master");
  mosi_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    spi_m |-> pad_oe_n_o[PIN_MOSI] == !dir_w[PIN_MOSI])
    else $error("mosi direction as master");
  stage_pin1_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    stage2_out_enable_i[0] |->
    !pad_oe_n_o[PIN_ST2_0] && pad_o[PIN_ST2_0] == stage2_out_i[0])
    else $error("stage pin 1");
  stage_pin2_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    stage2_out_enable_i[1] |->
    !pad_oe_n_o[PIN_ST2_1] && pad_o[PIN_ST2_1] == stage2_out_i[1])
    else $error("stage pin 2");
  stage_pin0_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    stage2_out_enable_i[3] |->
    !pad_oe_n_o[PIN_ST2_3] && pad_o[PIN_ST2_3] == stage2_out_i[3])
    else $error("stage pin 0");
  retrig_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    retrig_stage_out1_enable_i |-> !pad_oe_n_o[PIN_RETRIG1])
    else $error("retrig pin not driven");
  retrig_plain_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    !retrig_stage_out1_enable_i |-> pad_oe_n_o[PIN_RETRIG1] == !dir_w[PIN_RETRIG1])
    else $error("retrig pin direction");
  cmp_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    comparator3_out_enable_i |-> !pad_oe_n_o[PIN_ST2_3])
    else $error("comparator pin not driven");
  capture_feed_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (!analog_input_disable_i[PIN_CAPTURE] && !sleep_i) |->
    timer1_capture_input_o == pad_i[PIN_CAPTURE]) else $error("capture input");
  count_feed_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (!analog_input_disable_i[PIN_COUNT] && !sleep_i) |->
    timer1_count_input_o == pad_i[PIN_COUNT]) else $error("count input");
  irq0_feed_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    ext_irq0_enabled_i |-> ext_irq0_input_o == pad_i[PIN_IRQ0])
    else $error("irq0 input");
  irq1_feed_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    ext_irq1_enabled_i |-> ext_irq1_input_o == pad_i[PIN_IRQ1])
    else $error("irq1 input");
  capture_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    analog_input_disable_i[PIN_CAPTURE] |-> !timer1_capture_input_o)
    else $error("capture input not disabled");
  count_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    analog_input_disable_i[PIN_COUNT] |-> !timer1_count_input_o)
    else $error("count input not disabled");
  irq1_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (sleep_i && !ext_irq1_enabled_i) |-> !ext_irq1_input_o)
    else $error("irq1 not clamped");
  miso_plain_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    !spi_block_enable_i |-> pad_oe_n_o[PIN_MISO] == !dir_w[PIN_MISO])
    else $error("miso plain direction");
  miso_value_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (!spi_block_enable_i && dir_w[PIN_MISO]) |-> pad_o[PIN_MISO] == out_w[PIN_MISO])
    else $error("miso plain value");
  idle_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (pad_o & pad_oe_n_o) == 8'h00)
    else $error("value on undriven pin");
  pin1_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    (!dir_w[PIN_ST2_0] && out_w[PIN_ST2_0] && !global_pullup_disable) |-> pullup_o[PIN_ST2_0])
    else $error("pin 1 pull-up off");
  pin7_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    pullup_o[PIN_ST2_2] == (~dir_w[PIN_ST2_2] & out_w[PIN_ST2_2] & ~global_pullup_disable))
    else $error("pin 7 pull-up");
  sck_sample_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (spi_s && !sleep_i && !analog_input_disable_i[PIN_SCK]) |->
    spi_sck_in_o == pad_i[PIN_SCK]) else $error("sck input");
  mosi_sample_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (spi_s && !sleep_i && !analog_input_disable_i[PIN_MOSI]) |->
    spi_mosi_in_o == pad_i[PIN_MOSI]) else $error("mosi input");
  miso_sample_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (spi_m && !sleep_i && !analog_input_disable_i[PIN_MISO]) |->
    spi_miso_in_o == pad_i[PIN_MISO]) else $error("miso input");
endmodule

// File: hdl/pbm_pkg.sv
// Constants for the port B alternate-function mux.
// Assumes a single 25 MHz clock and a classic Wishbone register slave.
package pbm_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_MCU_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PORT_OUT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PIN_IN = 4'hC;
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MCU_CONTROL_WMASK = 8'h1F;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam int BIT_PULLUP_DIS = 4;
  // ****************************************************************
  // Pin positions
  // ****************************************************************
  localparam int PIN_CNT = 8;
  localparam int PIN_MISO = 6;
  localparam int PIN_SCK = 5;
  localparam int PIN_MOSI = 4;
  localparam int PIN_RETRIG1 = 3;
  localparam int PIN_ST2_0 = 1;
  localparam int PIN_ST2_1 = 2;
  localparam int PIN_ST2_2 = 7;
  localparam int PIN_ST2_3 = 0;
  localparam int PIN_CAPTURE = 7;
  localparam int PIN_COUNT = 0;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_IRQ1 = 5;
  // Bus answer state.
  typedef enum logic {PBM_IDLE = 1'b0, PBM_ACK = 1'b1} pbm_bus_t;
endpackage

// File: hdl/pbm_pin_cell.sv
// One pin's override logic: pull-up, direction, value and input enable.
// Assumes override signals come from the mux top, all combinational.
module pbm_pin_cell (
  input wire logic dir_bit_i,
  input wire logic out_bit_i,
  input wire logic pullup_dis_i,
  input wire logic sleep_i,
  input wire logic pullup_ovr_en_i,
  input wire logic pullup_ovr_val_i,
  input wire logic dir_ovr_en_i,
  input wire logic dir_ovr_val_i,
  input wire logic value_ovr_en_i,
  input wire logic value_ovr_val_i,
  input wire logic input_enable_ovr_en_i,
  input wire logic input_enable_ovr_val_i,
  input wire logic pad_i,
  output logic drive_en_o,
  output logic drive_val_o,
  output logic pullup_o,
  output logic din_o
);
  wire logic plain_pullup;
  wire logic in_en;
  // Pull-up on only for input with output bit set and no global disable.
  assign plain_pullup = ~dir_bit_i & out_bit_i & ~pullup_dis_i; // [R15] [R1]
  assign pullup_o = pullup_ovr_en_i ? pullup_ovr_val_i : plain_pullup;
  assign drive_en_o = dir_ovr_en_i ? dir_ovr_val_i : dir_bit_i; // [R16]
  assign drive_val_o = drive_en_o & (value_ovr_en_i ? value_ovr_val_i : out_bit_i); // [R17]
  assign in_en = input_enable_ovr_en_i ? input_enable_ovr_val_i : ~sleep_i; // [R13]
  assign din_o = pad_i & in_en;
endmodule

// File: hdl/pbm_wb_regs.sv
// Wishbone classic slave holding mcu_control, port direction and output.
// Assumes a master that holds each request until ack.
module pbm_wb_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pbm_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_state_i,
  output logic [7:0] mcu_control_o,
  output logic [7:0] port_dir_o,
  output logic [7:0] port_out_o
);
  import pbm_pkg::*;
  logic [7:0] mcu_q, dir_q, out_q;
  logic [31:0] rdat_q;
  pbm_bus_t st_q;
  wire logic req = wb_cyc_i & wb_stb_i & (st_q == PBM_IDLE);
  wire logic wr = wb_ack_o & wb_we_i & wb_sel_i[0];
  wire logic hit_mcu = wb_adr_i == OFS_MCU_CONTROL;
  wire logic hit_dir = wb_adr_i == OFS_PORT_DIR;
  wire logic hit_out = wb_adr_i == OFS_PORT_OUT;
  wire logic hit_pin = wb_adr_i == OFS_PIN_IN;
  wire logic [7:0] rsel = hit_mcu ? mcu_q : hit_dir ? dir_q : hit_out ? out_q :
                          hit_pin ? pin_state_i : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcu_q <= MCU_CONTROL_RESET;
      dir_q <= PORT_RESET;
      out_q <= PORT_RESET;
      rdat_q <= 32'h0000_0000;
      st_q <= PBM_IDLE;
    end else begin
      st_q <= req ? PBM_ACK : PBM_IDLE;
      if (req) begin
        rdat_q <= {24'h00_0000, rsel};
      end
      if (wr && hit_mcu) begin
        mcu_q <= wb_dat_i[7:0] & MCU_CONTROL_WMASK;
      end
      if (wr && hit_dir) begin
        dir_q <= wb_dat_i[7:0];
      end
      if (wr && hit_out) begin
        out_q <= wb_dat_i[7:0];
      end
    end
  end
  assign wb_ack_o = (st_q == PBM_ACK) & wb_cyc_i & wb_stb_i;
  assign wb_dat_o = rdat_q;
  assign mcu_control_o = mcu_q;
  assign port_dir_o = dir_q;
  assign port_out_o = out_q;
endmodule

// File: verification/pbm_periph_model.sv
// Behavioural model of the peripherals that own port B pins.
// Assumes the bench sets the control word just after a rising edge.
module pbm_periph_model (
  input wire logic clk_i,
  input wire logic [16:0] ctl_i,
  output logic spi_en_o,
  output logic spi_mst_o,
  output logic sck_o,
  output logic mosi_o,
  output logic miso_o,
  output logic [3:0] st2_o,
  output logic [3:0] st2_en_o,
  output logic rt_o,
  output logic rt_en_o,
  output logic cmp_o,
  output logic cmp_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Registered peripheral outputs
  // ****************************************************************
  // Every peripheral output changes only on the shared clock.
  always_ff @(posedge clk_i) begin
    {spi_en_o, spi_mst_o, sck_o, mosi_o, miso_o, st2_o, st2_en_o,
     rt_o, rt_en_o, cmp_o, cmp_en_o} <= ctl_i;
  end
endmodule

// File: verification/pbm_port_b_mux_tb.sv
// Self-checking bench for the port B alternate-function mux.
// Assumes a Wishbone slave answering one cycle after the take edge.
module pbm_port_b_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pbm_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, sleep = 0, e0 = 0, e1 = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = '0, rdat, q;
  logic [7:0] ext = 8'h00, pin, pout, oe_n, pu, adis = 8'h00, mcu;
  logic [16:0] ctl = '0;
  logic se, sm, sck, mosi, miso, rt, rte, cm, cme, si0, si1, si2, cap, cnt, i0, i1;
  logic [3:0] st, ste;
  int num_errors = 0, n_checks = 0;
  // Pin level: the mux output where it drives, else the outside level.
  assign pin = (~oe_n & pout) | (oe_n & ext);
  pbm_periph_model model (.clk_i(clk), .ctl_i(ctl), .spi_en_o(se), .spi_mst_o(sm),
    .sck_o(sck), .mosi_o(mosi), .miso_o(miso), .st2_o(st), .st2_en_o(ste), .rt_o(rt),
    .rt_en_o(rte), .cmp_o(cm), .cmp_en_o(cme));
  pbm_port_b_mux dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pad_i(pin), .pad_o(pout), .pad_oe_n_o(oe_n), .pullup_o(pu),
    .sleep_i(sleep), .spi_block_enable_i(se), .spi_master_select_i(sm),
    .spi_sck_out_i(sck), .spi_mosi_out_i(mosi), .spi_miso_out_i(miso),
    .spi_sck_in_o(si0), .spi_mosi_in_o(si1), .spi_miso_in_o(si2), .stage2_out_i(st),
    .stage2_out_enable_i(ste), .retrig_stage_out1_i(rt), .retrig_stage_out1_enable_i(rte),
    .comparator3_output_i(cm), .comparator3_out_enable_i(cme),
    .analog_input_disable_i(adis), .ext_irq0_enabled_i(e0), .ext_irq1_enabled_i(e1),
    .timer1_capture_input_o(cap), .timer1_count_input_o(cnt), .ext_irq0_input_o(i0),
    .ext_irq1_input_o(i1), .mcu_control_o(mcu));
  // ****************************************************************
  // Clock, watchdog and helpers
  // ****************************************************************
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; ack and read data are taken at the same rising edge.
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic per(input logic [16:0] v);
    ctl <= v;
    repeat (3) @(posedge clk);
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_MCU_CONTROL, 32'h0);
    rd(4'h2, 32'h0);
    wb(1'b1, OFS_MCU_CONTROL, 32'hFF);
    rd(OFS_MCU_CONTROL, 32'h1F);
    check(mcu, 8'h1F);
    wb(1'b1, OFS_MCU_CONTROL, 32'h0F);
    wb(1'b1, OFS_PORT_OUT, 32'hFF);
    check(pu, 8'hFF);
    wb(1'b1, OFS_MCU_CONTROL, 32'h10);
    check(pu, 8'h00);
    wb(1'b1, OFS_MCU_CONTROL, 32'h00);
    wb(1'b1, OFS_PORT_DIR, 32'hFF);
    wb(1'b1, OFS_PORT_OUT, 32'h70);
    ext <= 8'h40;
    per(17'h1C000);
    check(oe_n[6:4], 3'b100);
    check(pout[5:4], 2'b10);
    check({si0, si1}, 2'b10);
    check(pu[6:4], 3'b100);
    check(si2, 1'b1);
    per(17'h11000);
    check(oe_n[6:4], 3'b011);
    check(pout[6], 1'b1);
    check(pu[6:4], 3'b011);
    wb(1'b1, OFS_MCU_CONTROL, 32'h10);
    check(pu[6:4], 3'b000);
    wb(1'b1, OFS_MCU_CONTROL, 32'h00);
    wb(1'b1, OFS_PORT_DIR, 32'h00);
    wb(1'b1, OFS_PORT_OUT, 32'h00);
    per(17'h0027F);
    check(oe_n, 8'h70);
    check(pout & 8'h8F, 8'h0D);
    per(17'h002FF);
    check({oe_n[0], pout[0]}, 2'b00);
    per(17'h0027A);
    check(oe_n[0], 1'b1);
    check(pout[0], 1'b0);
    per(17'h0);
    ext <= 8'hA5;
    repeat (2) @(posedge clk);
    check({cap, cnt, i0, i1}, 4'hF);
    rd(OFS_PIN_IN, 32'hA5);
    adis <= 8'h84;
    e0 <= 1'b1;
    repeat (2) @(posedge clk);
    check({cap, cnt, i0}, 3'b011);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    check({cnt, i0, i1}, 3'b010);
    test_done();
  end
endmodule
